// ===== verilog/sds_params.svh
/*
  Constants of the serial DMA status block: register offsets, field positions,
  reset values and widths. Assumes a 16-bit register port and one clock.
*/
// How it works
// - Byte carrying an overrun error stored into buffer B sets status bit 5.
// - Byte carrying an overrun error stored into buffer A sets status bit 4.
// - Overrun error rides up with the FIFO drain into the next loaded buffer.
// - Pending overrun goes to buffer B when B is loaded next and drains FIFO.
// - Buffer B overrun flag clears on next load of B or receive reset.
// - Buffer A overrun flag clears on next load of A or receive reset.
// - Status bits 3 and 2 show transmit buffer B and A in use.
// - Status bit 1 shows receive buffer B in use.
// - Status bit 0 shows receive buffer A in use.
// - Thirteen-bit read-only offset of next byte position in receive buffer A.
// - Offset of buffer A returns to zero when buffer fills and unloads.
// - Unused status bits and upper offset bits read zero, read-only.
`ifndef SDS_PARAMS_SVH
`define SDS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define SDS_ADDR_W      16
`define SDS_DATA_W      16
`define SDS_OFF_CNT_A   16'h4410
`define SDS_OFF_STATE   16'h4416
`define SDS_OFF_CTRL    16'h4418
`define SDS_OFF_IRQ_ST  16'h441a
`define SDS_OFF_IRQ_MSK 16'h441c

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define SDS_CNT_W       13
`define SDS_BUF_A       0
`define SDS_BUF_B       1
`define SDS_CTL_RXLD_A  0
`define SDS_CTL_RXLD_B  1
`define SDS_CTL_TXLD_A  2
`define SDS_CTL_TXLD_B  3
`define SDS_CTL_RXRST   4
`define SDS_CTL_TXRST   5
`define SDS_IRQ_W       6
`define SDS_IRQ_OVR     0
`define SDS_IRQ_RXDONE  2
`define SDS_IRQ_TXDONE  4
`define SDS_ZERO_W      10
`define SDS_RST_CNT     13'h0000
`define SDS_RST_DATA    16'h0000
`define SDS_RST_IRQ     6'h00

`endif

// ===== verilog/sds_pkg.sv
/*
  Types of the serial DMA status block.
  Assumes sds_params.svh is on the include path.
*/
`include "sds_params.svh"

package sds_pkg;

  // --------------------------------------------------------------------------
  // Buffer pair state, Gray along idle, A, B
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SDS_IDLE = 2'h0,
    SDS_ON_A = 2'h1,
    SDS_ON_B = 2'h3
  } sds_pp_state_t;

  typedef struct packed {
    logic [`SDS_ZERO_W-1:0] zero;
    logic                   ovf_b;
    logic                   ovf_a;
    logic                   tx_b;
    logic                   tx_a;
    logic                   rx_b;
    logic                   rx_a;
  } sds_stat_t;

  typedef struct packed {
    logic       ovr;
    logic [7:0] data;
  } sds_rxbyte_t;

  typedef struct packed {
    logic                  buf_b;
    logic [`SDS_CNT_W-1:0] offset;
    logic [7:0]            data;
  } sds_store_t;

endpackage : sds_pkg

// ===== verilog/sds_pingpong.sv
/*
  Two-buffer load and turn keeping for one DMA direction.
  Assumes load requests and the done pulse come from logic on mclk.
*/
`timescale 1ns/1ps
`include "sds_params.svh"

module sds_pingpong (
  input  wire logic       mclk,     // System clock
  input  wire logic       rst,      // Async reset, high
  input  wire logic       dma_rst,  // Direction reset pulse
  input  wire logic [1:0] load_set, // Load request per buffer
  input  wire logic       done,     // Buffer in use completes
  output logic      [1:0] loaded,   // Load bits, active or pending
  output logic      [1:0] active    // Buffer in use
);
  import sds_pkg::*;

  sds_pp_state_t state_r;
  sds_pp_state_t state_nxt;
  logic [1:0]    load_r;
  logic          next_b_r;
  logic [1:0]    clr;

  assign clr    = done ? active : 2'h0;
  assign loaded = load_r;
  assign active = {state_r == SDS_ON_B, state_r == SDS_ON_A};

  // A new load beats a completion in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) load_r <= 2'h0;
    else if (dma_rst) load_r <= 2'h0;
    else load_r <= (load_r & ~clr) | load_set;
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SDS_IDLE: begin
        if (load_r[next_b_r]) state_nxt = next_b_r ? SDS_ON_B : SDS_ON_A;
        else if (load_r[~next_b_r]) state_nxt = next_b_r ? SDS_ON_A : SDS_ON_B;
      end
      SDS_ON_A: if (done) state_nxt = load_r[`SDS_BUF_B] ? SDS_ON_B : SDS_IDLE;
      SDS_ON_B: if (done) state_nxt = load_r[`SDS_BUF_A] ? SDS_ON_A : SDS_IDLE;
      default:  state_nxt = SDS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) state_r <= SDS_IDLE;
    else if (dma_rst) state_r <= SDS_IDLE;
    else state_r <= state_nxt;
  end

  // Turn pointer: after a buffer completes the other one is next
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) next_b_r <= 1'b0;
    else if (dma_rst) next_b_r <= 1'b0;
    else if (done) next_b_r <= (state_r == SDS_ON_A);
  end

endmodule : sds_pingpong

// ===== verilog/sds_dma_status.sv
/*
  Status and receive offset logic of the serial DMA engine, with its control,
  interrupt registers and the store port toward buffer memory.
  Assumes the lower FIFO, the transmit engine and buffer limits run on mclk.
*/
`timescale 1ns/1ps
`include "sds_params.svh"

module sds_dma_status (
  input  wire logic                    mclk,        // System clock, 200 MHz
  input  wire logic                    rst,         // Async reset, high
  input  wire logic [`SDS_ADDR_W-1:0]  reg_addr,    // Register address
  input  wire logic [`SDS_DATA_W-1:0]  reg_wdata,   // Register write data
  input  wire logic                    reg_wr,      // Write strobe
  input  wire logic                    reg_rd,      // Read strobe
  output logic      [`SDS_DATA_W-1:0]  reg_rdata,   // Read data, next cycle
  input  wire sds_pkg::sds_rxbyte_t    rx_byte,     // Byte drained from FIFO
  input  wire logic                    rx_byte_vld, // Byte offered
  output logic                         rx_byte_rdy, // A buffer takes bytes
  input  wire logic [`SDS_CNT_W-1:0]   rx_last_a,   // Last offset of buffer A
  input  wire logic [`SDS_CNT_W-1:0]   rx_last_b,   // Last offset of buffer B
  input  wire logic [1:0]              tx_done,     // Transmit buffer finished
  output logic      [1:0]              tx_load,     // Transmit load bits
  output logic                         tx_dma_rst,  // Transmit reset pulse
  output sds_pkg::sds_store_t          store,       // Byte to buffer memory
  output logic                         store_vld,   // Store valid pulse
  output logic                         irq          // Interrupt, level
);
  import sds_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [`SDS_CNT_W-1:0]  rx_cnt_r [2];
  logic [`SDS_CNT_W-1:0]  rx_last  [2];
  logic [1:0]             rx_ovf_r;
  logic [1:0]             rx_hit;
  logic [1:0]             rx_at_last;
  logic [1:0]             rx_act;
  logic [1:0]             rx_loaded;
  logic [1:0]             tx_act;
  logic [1:0]             rx_ld_set;
  logic [1:0]             tx_ld_set;
  logic                   rx_rst;
  logic                   ctl_wr;
  logic                   store_en;
  logic                   rx_done;
  logic [`SDS_IRQ_W-1:0]  irq_st_r;
  logic [`SDS_IRQ_W-1:0]  irq_msk_r;
  logic [`SDS_IRQ_W-1:0]  irq_ev;
  logic [`SDS_DATA_W-1:0] rdata_nxt;
  sds_stat_t              stat;
  sds_store_t             store_r;
  logic                   store_vld_r;

  function automatic logic addr_is(input logic [`SDS_ADDR_W-1:0] a,
                                   input logic [`SDS_ADDR_W-1:0] off);
    addr_is = (a == off);
  endfunction : addr_is

  // --------------------------------------------------------------------------
  // Control register decode
  // --------------------------------------------------------------------------
  assign ctl_wr = reg_wr & addr_is(reg_addr, `SDS_OFF_CTRL);
  assign rx_rst = ctl_wr & reg_wdata[`SDS_CTL_RXRST];
  assign tx_dma_rst = ctl_wr & reg_wdata[`SDS_CTL_TXRST];

  // A reset in the same write wins over loads of that direction
  assign rx_ld_set = (ctl_wr & ~reg_wdata[`SDS_CTL_RXRST]) ?
                     reg_wdata[`SDS_CTL_RXLD_B:`SDS_CTL_RXLD_A] : 2'h0;
  assign tx_ld_set = (ctl_wr & ~reg_wdata[`SDS_CTL_TXRST]) ?
                     reg_wdata[`SDS_CTL_TXLD_B:`SDS_CTL_TXLD_A] : 2'h0;

  // --------------------------------------------------------------------------
  // Buffer turn keeping
  // --------------------------------------------------------------------------
  sds_pingpong u_rx_pp (
    .mclk     (mclk),
    .rst      (rst),
    .dma_rst  (rx_rst),
    .load_set (rx_ld_set),
    .done     (rx_done),
    .loaded   (rx_loaded),
    .active   (rx_act)
  );

  sds_pingpong u_tx_pp (
    .mclk     (mclk),
    .rst      (rst),
    .dma_rst  (tx_dma_rst),
    .load_set (tx_ld_set),
    .done     (|(tx_done & tx_act)),
    .loaded   (tx_load),
    .active   (tx_act)
  );

  // --------------------------------------------------------------------------
  // Receive path
  // --------------------------------------------------------------------------
  // While no buffer is active the FIFO backs up; its overrun mark then
  // arrives on the first byte drained into whichever buffer is loaded next.
  assign rx_byte_rdy = |rx_act;
  assign store_en    = rx_byte_vld & rx_byte_rdy;
  assign rx_last[`SDS_BUF_A] = rx_last_a;
  assign rx_last[`SDS_BUF_B] = rx_last_b;
  assign rx_done = |(rx_hit & rx_at_last);

  for (genvar g = 0; g < 2; g++) begin : g_rx
    assign rx_hit[g]     = store_en & rx_act[g];
    assign rx_at_last[g] = (rx_cnt_r[g] == rx_last[g]);

    // Offset wraps to the first location as the full buffer unloads
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) rx_cnt_r[g] <= `SDS_RST_CNT;
      else if (rx_rst) rx_cnt_r[g] <= `SDS_RST_CNT;
      else if (rx_hit[g] & rx_at_last[g]) rx_cnt_r[g] <= `SDS_RST_CNT;
      else if (rx_hit[g]) rx_cnt_r[g] <= rx_cnt_r[g] + 13'h0001;
    end

    // Flag follows the buffer that took the marked byte; set beats clear
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) rx_ovf_r[g] <= 1'b0;
      else if (rx_hit[g] & rx_byte.ovr) rx_ovf_r[g] <= 1'b1;
      else if (rx_rst | rx_ld_set[g]) rx_ovf_r[g] <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      store_r <= '0;
    end else if (store_en) begin
      store_r.buf_b  <= rx_act[`SDS_BUF_B];
      store_r.offset <= rx_act[`SDS_BUF_B] ? rx_cnt_r[`SDS_BUF_B] :
                                             rx_cnt_r[`SDS_BUF_A];
      store_r.data   <= rx_byte.data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) store_vld_r <= 1'b0;
    else store_vld_r <= store_en;
  end

  assign store     = store_r;
  assign store_vld = store_vld_r;

  // --------------------------------------------------------------------------
  // Status word
  // --------------------------------------------------------------------------
  always_comb begin
    stat       = '0;
    stat.ovf_b = rx_ovf_r[`SDS_BUF_B];
    stat.ovf_a = rx_ovf_r[`SDS_BUF_A];
    stat.tx_b  = tx_act[`SDS_BUF_B];
    stat.tx_a  = tx_act[`SDS_BUF_A];
    stat.rx_b  = rx_act[`SDS_BUF_B];
    stat.rx_a  = rx_act[`SDS_BUF_A];
  end

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  assign irq_ev = {tx_done & tx_act, rx_hit & rx_at_last,
                   rx_hit & {2{rx_byte.ovr}}};

  // Write one clears; a new event in the same cycle keeps its bit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) irq_st_r <= `SDS_RST_IRQ;
    else if (reg_wr & addr_is(reg_addr, `SDS_OFF_IRQ_ST))
      irq_st_r <= (irq_st_r & ~reg_wdata[`SDS_IRQ_W-1:0]) | irq_ev;
    else irq_st_r <= irq_st_r | irq_ev;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) irq_msk_r <= `SDS_RST_IRQ;
    else if (reg_wr & addr_is(reg_addr, `SDS_OFF_IRQ_MSK))
      irq_msk_r <= reg_wdata[`SDS_IRQ_W-1:0];
  end

  assign irq = |(irq_st_r & irq_msk_r);

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  // Offset and status are read-only; writes to them are ignored.
  always_comb begin
    rdata_nxt = `SDS_RST_DATA;
    if (addr_is(reg_addr, `SDS_OFF_CNT_A))
      rdata_nxt = {3'h0, rx_cnt_r[`SDS_BUF_A]};
    else if (addr_is(reg_addr, `SDS_OFF_STATE))
      rdata_nxt = stat;
    else if (addr_is(reg_addr, `SDS_OFF_CTRL))
      rdata_nxt = {12'h000, tx_load, rx_loaded};
    else if (addr_is(reg_addr, `SDS_OFF_IRQ_ST))
      rdata_nxt = {10'h000, irq_st_r};
    else if (addr_is(reg_addr, `SDS_OFF_IRQ_MSK))
      rdata_nxt = {10'h000, irq_msk_r};
  end

  // Data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) reg_rdata <= `SDS_RST_DATA;
    else if (reg_rd) reg_rdata <= rdata_nxt;
    else reg_rdata <= `SDS_RST_DATA;
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_ovf_b_set: assert property (
    rx_hit[`SDS_BUF_B] && rx_byte.ovr |=> stat.ovf_b)
    else $error("overrun b not flagged");

  chk_ovf_a_set: assert property (
    rx_hit[`SDS_BUF_A] && rx_byte.ovr |=> stat.ovf_a)
    else $error("overrun a not flagged");

  chk_no_store_idle: assert property (
    !(|rx_act) |-> !rx_byte_rdy ##1 !store_vld)
    else $error("byte taken with no active buffer");

  chk_pend_to_b: assert property (
    rx_hit[`SDS_BUF_B] && rx_byte.ovr && !rx_ovf_r[`SDS_BUF_A]
    |=> stat.ovf_b && !stat.ovf_a)
    else $error("overrun attributed to wrong buffer");

  chk_ovf_b_clr: assert property (
    rx_ld_set[`SDS_BUF_B] && !rx_hit[`SDS_BUF_B] |=> !stat.ovf_b)
    else $error("overrun b kept after load");

  chk_ovf_a_clr: assert property (
    rx_ld_set[`SDS_BUF_A] && !rx_hit[`SDS_BUF_A] |=> !stat.ovf_a)
    else $error("overrun a kept after load");

  chk_act_loaded: assert property (
    (stat.tx_a |-> tx_load[`SDS_BUF_A]) and (stat.tx_b |-> tx_load[`SDS_BUF_B])
    and !(stat.tx_a && stat.tx_b))
    else $error("tx active without load");

  chk_rx_b_act: assert property (
    stat.rx_b |-> rx_loaded[`SDS_BUF_B] && !stat.rx_a)
    else $error("rx b active without load");

  chk_rx_a_act: assert property (
    stat.rx_a |-> rx_loaded[`SDS_BUF_A])
    else $error("rx a active without load");

  chk_cnt_read: assert property (
    reg_rd && addr_is(reg_addr, `SDS_OFF_CNT_A)
    |=> reg_rdata[`SDS_CNT_W-1:0] == $past(rx_cnt_r[`SDS_BUF_A]))
    else $error("offset read mismatch");

  chk_cnt_wrap: assert property (
    rx_hit[`SDS_BUF_A] && rx_at_last[`SDS_BUF_A] && !rx_rst
    |=> rx_cnt_r[`SDS_BUF_A] == `SDS_RST_CNT &&
        (!rx_loaded[`SDS_BUF_A] || $past(rx_ld_set[`SDS_BUF_A])))
    else $error("offset did not wrap");

  chk_rd_zero: assert property (
    reg_rd && (addr_is(reg_addr, `SDS_OFF_STATE) ||
               addr_is(reg_addr, `SDS_OFF_CNT_A))
    |=> reg_rdata[`SDS_DATA_W-1:`SDS_CNT_W] == 3'h0 &&
        ($past(addr_is(reg_addr, `SDS_OFF_CNT_A)) ||
         reg_rdata[`SDS_DATA_W-1:6] == 10'h000))
    else $error("reserved bits not zero");

  chk_rx_reset: assert property (
    rx_rst && !(store_en && rx_byte.ovr)
    |=> rx_act == 2'h0 && rx_ovf_r == 2'h0 ##1 rx_act == 2'h0)
    else $error("receive reset incomplete");

  chk_done_clears: assert property (
    rx_done && !rx_ld_set[`SDS_BUF_A] && rx_act[`SDS_BUF_A]
    |=> !rx_act[`SDS_BUF_A] && !rx_loaded[`SDS_BUF_A])
    else $error("buffer a still active after done");

  chk_cnt_step: assert property (
    rx_hit[`SDS_BUF_A] && !rx_at_last[`SDS_BUF_A] && !rx_rst
    |=> rx_cnt_r[`SDS_BUF_A] == $past(rx_cnt_r[`SDS_BUF_A]) + 13'h0001)
    else $error("offset did not step");

  chk_irq_level: assert property (
    |(irq_ev & irq_msk_r) && !(reg_wr && addr_is(reg_addr, `SDS_OFF_IRQ_MSK))
    |=> irq)
    else $error("interrupt missing");

  // Overrun flags are sticky: only a load of their buffer or a receive reset
  // drops them, so a missed mark cannot hide behind a later clean byte.
  chk_ovf_b_hold: assert property (
    rx_ovf_r[`SDS_BUF_B] && !rx_rst && !rx_ld_set[`SDS_BUF_B]
    |=> rx_ovf_r[`SDS_BUF_B])
    else $error("overrun b dropped early");

  chk_ovf_a_hold: assert property (
    rx_ovf_r[`SDS_BUF_A] && !rx_rst && !rx_ld_set[`SDS_BUF_A]
    |=> rx_ovf_r[`SDS_BUF_A])
    else $error("overrun a dropped early");

  chk_store_a: assert property (
    store_en && rx_act[`SDS_BUF_A]
    |=> store_vld && !store.buf_b && store.offset == $past(rx_cnt_r[`SDS_BUF_A]))
    else $error("store to a at wrong offset");

  chk_store_b: assert property (
    store_en && rx_act[`SDS_BUF_B] |=> store_vld && store.buf_b)
    else $error("store to b not marked");

  chk_stat_read: assert property (
    reg_rd && addr_is(reg_addr, `SDS_OFF_STATE) |=> reg_rdata == $past(stat))
    else $error("status read mismatch");

  chk_rd_idle: assert property (
    !reg_rd |=> reg_rdata == `SDS_RST_DATA)
    else $error("read data outside read cycle");

  chk_cnt_ro: assert property (
    reg_wr && addr_is(reg_addr, `SDS_OFF_CNT_A) && !rx_hit[`SDS_BUF_A] && !rx_rst
    |=> $stable(rx_cnt_r[`SDS_BUF_A]))
    else $error("offset changed by write");

  chk_tx_reset: assert property (
    tx_dma_rst |=> tx_act == 2'h0 && tx_load == 2'h0)
    else $error("transmit reset incomplete");

  cov_ovf_a: cover property (rx_hit[`SDS_BUF_A] && rx_byte.ovr);
  cov_a_to_b: cover property (rx_done && rx_act[`SDS_BUF_A] ##1 rx_act[`SDS_BUF_B]);
  cov_tx_done: cover property (|(tx_done & tx_act));
  cov_rx_rst: cover property (rx_rst && (|rx_act));
  cov_irq_rise: cover property ($rose(irq));

endmodule : sds_dma_status

// ===== dv/sds_fifo_model.sv
/*
  Behavioural lower receive FIFO that offers a burst of bytes to the DMA engine.
  Assumes the engine samples rx_byte_vld and rx_byte_rdy on the rising mclk.
*/
`timescale 1ns/1ps

module sds_fifo_model (
  input  wire logic           mclk,      // System clock
  input  wire logic           rst,       // Async reset, high
  input  wire logic           start,     // Begin a burst
  input  wire logic [7:0]     count,     // Bytes in the burst
  input  wire logic           ovr_first, // First byte carries an overrun mark
  input  wire logic           rdy,       // Engine takes bytes
  output sds_pkg::sds_rxbyte_t rx_byte,  // Byte offered
  output logic                vld,       // Byte offered
  output logic                busy       // Burst not yet drained
);
  import sds_pkg::*;

  // --------------------------------------------------------------------------
  // Burst state
  // --------------------------------------------------------------------------
  logic [7:0] left_r;
  logic [7:0] seq_r;
  logic       ovr_r;

  assign vld  = (left_r != 8'h00);
  assign busy = vld;
  // Idle lines show the inverse of the next byte in sequence, so stale data never passes as valid
  assign rx_byte = vld ? {ovr_r, seq_r} : {~ovr_r, ~seq_r};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      left_r <= 8'h00;
      seq_r  <= 8'h10;
      ovr_r  <= 1'b0;
    end else if (start) begin
      left_r <= count;
      ovr_r  <= ovr_first;
    end else if (vld && rdy) begin
      left_r <= left_r - 8'h01;
      seq_r  <= seq_r + 8'h01;
      ovr_r  <= 1'b0;
    end
  end
endmodule : sds_fifo_model

// ===== dv/sds_dma_status_test.sv
/*
  Self-checking testbench of the serial DMA status block with a FIFO model.
  Assumes sds_params.svh is on the include path and sds_pkg is compiled first.
*/
`timescale 1ns/1ps
`include "sds_params.svh"

module sds_dma_status_test;
  import sds_pkg::*;

  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic        mclk;
  logic        rst;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  sds_rxbyte_t rx_byte;
  logic        rx_byte_vld;
  logic        rx_byte_rdy;
  logic [12:0] rx_last_a;
  logic [12:0] rx_last_b;
  logic [1:0]  tx_done;
  logic [1:0]  tx_load;
  logic        tx_dma_rst;
  sds_store_t  store;
  logic        store_vld;
  logic        irq;
  logic        start;
  logic [7:0]  count;
  logic        ovr_first;
  logic        busy;
  sds_store_t  last_store;
  int          n_stores;
  int          sent;
  int          num_errors;
  int          n_compared;

  sds_dma_status sds_dma_status_inst (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_byte(rx_byte),
    .rx_byte_vld(rx_byte_vld), .rx_byte_rdy(rx_byte_rdy), .rx_last_a(rx_last_a),
    .rx_last_b(rx_last_b), .tx_done(tx_done), .tx_load(tx_load),
    .tx_dma_rst(tx_dma_rst), .store(store), .store_vld(store_vld), .irq(irq));

  sds_fifo_model sds_fifo_model_inst (
    .mclk(mclk), .rst(rst), .start(start), .count(count), .ovr_first(ovr_first),
    .rdy(rx_byte_rdy), .rx_byte(rx_byte), .vld(rx_byte_vld), .busy(busy));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Store pulses last one cycle, so they are caught here rather than polled
  always @(posedge mclk) begin
    if (store_vld === 1'b1) begin
      n_stores   <= n_stores + 1;
      last_store <= store;
    end
  end

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic read_check(input string what, input logic [15:0] a, input logic [15:0] exp);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    check(what, exp, reg_rdata);
  endtask : read_check

  task automatic burst(input logic [7:0] n, input logic ovr);
    int k;
    k = 0;
    @(posedge mclk);
    start     <= 1'b1;
    count     <= n;
    ovr_first <= ovr;
    @(posedge mclk);
    start     <= 1'b0;
    #1;
    sent = sent + n;
    while (busy !== 1'b0 && k < 200) begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (k == 200) begin
      num_errors++;
      $display("Error burst drain expected idle seen busy");
      conclude();
    end else begin
      repeat (2) @(posedge mclk);
      #1;
      check("store data", 32'(8'h10 + sent - 1), last_store.data);
    end
  endtask : burst

  task automatic pulse_tx(input logic [1:0] m);
    @(posedge mclk);
    tx_done <= m;
    @(posedge mclk);
    tx_done <= 2'b00;
    @(posedge mclk);
    #1;
  endtask : pulse_tx

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset();
    read_check("status", `SDS_OFF_STATE, 16'h0000);
    read_check("rx count a", `SDS_OFF_CNT_A, 16'h0000);
    read_check("unmapped", 16'h4420, 16'h0000);
    check("irq", 0, irq);
    check("rx ready", 0, rx_byte_rdy);
  endtask : t_reset

  task automatic t_overrun_a();
    reg_write(`SDS_OFF_CTRL, 16'h0001);
    burst(8'h01, 1'b1);
    check("stores", 1, n_stores);
    check("store buffer", 0, last_store.buf_b);
    check("store offset", 0, last_store.offset);
    read_check("status", `SDS_OFF_STATE, 16'h0011);
    read_check("rx count a", `SDS_OFF_CNT_A, 16'h0001);
    check("irq masked", 0, irq);
    reg_write(`SDS_OFF_IRQ_MSK, 16'h0005);
    @(posedge mclk);
    #1;
    check("irq raised", 1, irq);
    reg_write(`SDS_OFF_IRQ_ST, 16'h0001);
    @(posedge mclk);
    #1;
    check("irq cleared", 0, irq);
    read_check("irq mask", `SDS_OFF_IRQ_MSK, 16'h0005);
  endtask : t_overrun_a

  task automatic t_fill_a();
    burst(8'h03, 1'b0);
    check("store offset", 3, last_store.offset);
    read_check("rx count a", `SDS_OFF_CNT_A, 16'h0000);
    read_check("status", `SDS_OFF_STATE, 16'h0010);
    read_check("irq status", `SDS_OFF_IRQ_ST, 16'h0004);
    check("irq done", 1, irq);
    reg_write(`SDS_OFF_CTRL, 16'h0001);
    read_check("status", `SDS_OFF_STATE, 16'h0001);
  endtask : t_fill_a

  task automatic t_overrun_b();
    reg_write(`SDS_OFF_CTRL, 16'h0010);
    read_check("status", `SDS_OFF_STATE, 16'h0000);
    reg_write(`SDS_OFF_CTRL, 16'h0002);
    burst(8'h01, 1'b1);
    check("store buffer", 1, last_store.buf_b);
    read_check("status", `SDS_OFF_STATE, 16'h0022);
    reg_write(`SDS_OFF_CTRL, 16'h0010);
    read_check("status", `SDS_OFF_STATE, 16'h0000);
    reg_write(`SDS_OFF_CTRL, 16'h0002);
    burst(8'h01, 1'b1);
    reg_write(`SDS_OFF_CTRL, 16'h0002);
    read_check("status", `SDS_OFF_STATE, 16'h0002);
    reg_write(`SDS_OFF_CTRL, 16'h0010);
  endtask : t_overrun_b

  task automatic t_transmit();
    reg_write(`SDS_OFF_CTRL, 16'h000c);
    read_check("status", `SDS_OFF_STATE, 16'h0004);
    check("tx load", 2'b11, tx_load);
    read_check("control", `SDS_OFF_CTRL, 16'h000c);
    pulse_tx(2'b01);
    check("tx load", 2'b10, tx_load);
    read_check("status", `SDS_OFF_STATE, 16'h0008);
    pulse_tx(2'b10);
    read_check("irq status", `SDS_OFF_IRQ_ST, 16'h0036);
    read_check("status", `SDS_OFF_STATE, 16'h0000);
    reg_write(`SDS_OFF_CTRL, 16'h0004);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= `SDS_OFF_CTRL;
    reg_wdata <= 16'h0020;
    #1;
    check("tx reset", 1, tx_dma_rst);
    @(posedge mclk);
    reg_wr    <= 1'b0;
    read_check("status", `SDS_OFF_STATE, 16'h0000);
  endtask : t_transmit

  task automatic t_read_only();
    reg_write(`SDS_OFF_STATE, 16'hffff);
    reg_write(`SDS_OFF_CNT_A, 16'hffff);
    read_check("status", `SDS_OFF_STATE, 16'h0000);
    read_check("rx count a", `SDS_OFF_CNT_A, 16'h0000);
  endtask : t_read_only

  initial begin
    rst        = 1'b1;
    reg_addr   = 16'h0000;
    reg_wdata  = 16'h0000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    rx_last_a  = 13'h0003;
    rx_last_b  = 13'h0003;
    tx_done    = 2'b00;
    start      = 1'b0;
    count      = 8'h00;
    ovr_first  = 1'b0;
    n_stores   = 0;
    sent       = 0;
    num_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_overrun_a();
    t_fill_a();
    t_overrun_b();
    t_transmit();
    t_read_only();
    conclude();
  end
endmodule : sds_dma_status_test
